// ===== pafs_pkg.sv
// What this block does
// - Low selector: 32 bits, pins 0-7.
// - High selector: 32 bits, pins 8-15.
// - Codes 0-7 pick function; 8+ reserved.
// - Low selector at 0x20, resets zero.
// - High selector at 0x24, resets zero.
// - Clear writes of one clear latch bits.
// - Clear register write-only, reads zero.
// - Clear at 0x28; upper bits reserved zero.
// - Latch is 16-bit writable output data.
package pafs_pkg;
   // Register byte offsets within the port.
   localparam logic [7:0] PAFS_OFF_LATCH = 8'h14;
   localparam logic [7:0] PAFS_OFF_SET_CLR = 8'h18;
   localparam logic [7:0] PAFS_OFF_SEL_LO = 8'h20;
   localparam logic [7:0] PAFS_OFF_SEL_HI = 8'h24;
   localparam logic [7:0] PAFS_OFF_CLEAR = 8'h28;
   // Reset values.
   localparam logic [31:0] PAFS_SEL_RESET = 32'h0000_0000;
   localparam logic [15:0] PAFS_LATCH_RESET = 16'h0000;
   // Field geometry.
   localparam int PAFS_FIELD_W = 4;
   localparam int PAFS_PINS = 16;
   localparam int PAFS_HALF = 8;
   localparam int PAFS_SET_CLR_HI_LSB = 16;
   // Highest defined function code.
   localparam logic [3:0] PAFS_MAX_FUNC = 4'h7;
endpackage

// ===== pafs_func_decode.sv
// Turns one 4-bit selector field into a one-hot function select.
module pafs_func_decode
   import pafs_pkg::*;
(
   // Selector field.
   input wire logic [3:0] i_sel,
   // One-hot function choice; all zero for reserved codes.
   output logic [7:0] o_onehot
);
   // Reserved codes drive no function so a stray value cannot
   // connect two peripherals to one pin.
   wire valid_code = (i_sel <= PAFS_MAX_FUNC);
   assign o_onehot = valid_code ? (8'h01 << i_sel[2:0]) : 8'h00;
endmodule

// ===== pafs_port_altfunc.sv
// Port alternate function selection and output latch clearing.
//
// Our own choice: register access over APB.
module pafs_port_altfunc
   import pafs_pkg::*;
#(
   parameter int PINS = PAFS_PINS
)
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_reset,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Pin-side results.
   output logic [15:0] o_output_latch,
   output logic [127:0] o_func_onehot,
   output logic [63:0] o_pin_function_selector
);
   // Only a 16-pin port is served by the fixed register layout.
   if (PINS != PAFS_PINS) begin : g_bad_pins
      $error("pafs_port_altfunc supports 16 pins only");
   end

   // Registers.
   logic [31:0] sel_lo_ff; // Low selector register.
   logic [31:0] sel_hi_ff; // High selector register.
   logic [15:0] latch_ff; // Output latch.
   logic [31:0] nxt_sel_lo;
   logic [31:0] nxt_sel_hi;
   logic [15:0] nxt_latch;

   // Bus decode: a write takes effect only on the access edge.
   wire access = i_psel & i_penable;
   wire wr = access & i_pwrite;
   wire hit_lo = (i_paddr == PAFS_OFF_SEL_LO);
   wire hit_hi = (i_paddr == PAFS_OFF_SEL_HI);
   wire hit_clr = (i_paddr == PAFS_OFF_CLEAR);
   wire hit_latch = (i_paddr == PAFS_OFF_LATCH);
   wire hit_sc = (i_paddr == PAFS_OFF_SET_CLR);
   wire mapped = hit_lo | hit_hi | hit_clr | hit_latch | hit_sc;

   // Set/clear register: set wins when both are requested.
   wire [15:0] sc_set = i_pwdata[15:0];
   wire [15:0] sc_clr = i_pwdata[PAFS_SET_CLR_HI_LSB +: 16];
   wire [15:0] clr_bits = i_pwdata[15:0]; // Upper bits ignored.

   // Next-state selection.
   assign nxt_sel_lo = (wr && hit_lo) ? i_pwdata : sel_lo_ff;
   assign nxt_sel_hi = (wr && hit_hi) ? i_pwdata : sel_hi_ff;
   // Clear register: ones clear, zeros leave the bit alone.
   assign nxt_latch = !wr ? latch_ff :
                      hit_latch ? i_pwdata[15:0] :
                      hit_sc ? ((latch_ff & ~sc_clr) | sc_set) :
                      hit_clr ? (latch_ff & ~clr_bits) : latch_ff;

   // Registers update on the completing edge and show the new value the next cycle.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sel_lo_ff <= PAFS_SEL_RESET;
         sel_hi_ff <= PAFS_SEL_RESET;
         latch_ff <= PAFS_LATCH_RESET;
      end else begin
         sel_lo_ff <= nxt_sel_lo;
         sel_hi_ff <= nxt_sel_hi;
         latch_ff <= nxt_latch;
      end
   end

   // Read mux; the clear and set/clear registers hold no state and read zero.
   wire [31:0] rd_mux = hit_lo ? sel_lo_ff :
                        hit_hi ? sel_hi_ff :
                        hit_latch ? {16'h0000, latch_ff} :
                        32'h0000_0000;
   // Answer in the first access cycle; unmapped addresses flag an error.
   assign o_pready = 1'b1;
   assign o_pslverr = access & ~mapped;
   assign o_prdata = (access && !i_pwrite) ? rd_mux : 32'h0000_0000;

   assign o_output_latch = latch_ff;
   assign o_pin_function_selector = {sel_hi_ff, sel_lo_ff};

   // One decoder per pin.
   for (genvar p = 0; p < PAFS_PINS; p++) begin : g_dec
      pafs_func_decode u_dec (
         .i_sel(o_pin_function_selector[p*PAFS_FIELD_W +: PAFS_FIELD_W]),
         .o_onehot(o_func_onehot[p*8 +: 8])
      );
   end

   // Checks.
   sel_lo_upd_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit_lo) |=> (sel_lo_ff == $past(i_pwdata))) else $error("low select not written");
   sel_hi_upd_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit_hi) |=> (sel_hi_ff == $past(i_pwdata))) else $error("high select not written");
   reserved_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
      sel_lo_ff[3] |-> (o_func_onehot[7:0] == 8'h00)) else $error("reserved code active");
   lo_reset_a: assert property (@(posedge i_clk)
      i_reset |=> (sel_lo_ff == 32'h0000_0000)) else $error("low select reset wrong");
   hi_reset_a: assert property (@(posedge i_clk)
      i_reset |=> (sel_hi_ff == 32'h0000_0000)) else $error("high select reset wrong");
   clr_effect_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit_clr) |=> (latch_ff == ($past(latch_ff) & ~$past(i_pwdata[15:0]))))
      else $error("clear wrong");
   clr_reads_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (access && !i_pwrite && hit_clr) |-> (o_prdata == 32'h0000_0000)) else $error("clear read nonzero");
   clr_keep_sel_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit_clr) |=> $stable(sel_lo_ff) && $stable(sel_hi_ff)) else $error("clear disturbed select");
   latch_wr_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (wr && hit_latch) |=> (o_output_latch == $past(i_pwdata[15:0]))) else $error("latch write lost");
   idle_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !wr |=> $stable(latch_ff) && $stable(sel_lo_ff)) else $error("state changed without write");
endmodule

// ===== tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pafs_pkg::*;
   logic i_clk = 0, i_reset = 1, psel = 0, pen = 0, pwr = 0, er, rdy;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0, rd, lo, hi, w;
   logic [15:0] lat_m;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [15:0] latch;
   wire [127:0] oh;
   wire [63:0] sel;
   int num_errors = 0, cmp_count = 0;
   pafs_port_altfunc pafs_port_altfunc_inst (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_output_latch(latch), .o_func_onehot(oh),
      .o_pin_function_selector(sel));
   // Free-running 5 ns clock.
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   // One full APB transfer; request held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1; pwr <= wr; pa <= a; pwd <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      rdy = pready;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // Pin-side outputs against the model, one cycle after the last write landed.
   task automatic pins();
      logic [3:0] c;
      @(posedge i_clk);
      #1;
      chk("latch", {16'h0, lat_m}, {16'h0, latch});
      chk("sel_lo", lo, sel[31:0]);
      chk("sel_hi", hi, sel[63:32]);
      for (int p = 0; p < 16; p++) begin
         c = p < 8 ? lo[4*p+:4] : hi[4*(p-8)+:4];
         chk("onehot", c < 4'h8 ? 32'h1 << c : 32'h0, {24'h0, oh[8*p+:8]});
      end
   endtask
   task summarize();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Watchdog: the tests need well under 2000 cycles.
   initial begin
      #20000;
      num_errors++;
      summarize();
   end
   initial begin
      void'($urandom(54991));
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      lo = 32'h0; hi = 32'h0; lat_m = 16'h0;
      pins();
      // Random selectors, latch fill, then a random clear mask.
      for (int k = 0; k < 12; k++) begin
         lo = $urandom; hi = $urandom; w = $urandom;
         apb(1'b1, 8'h20, lo);
         apb(1'b1, 8'h24, hi);
         apb(1'b1, 8'h14, w); lat_m = w[15:0];
         w = $urandom;
         apb(1'b1, 8'h18, w); lat_m = (lat_m & ~w[31:16]) | w[15:0];
         w = $urandom;
         apb(1'b1, 8'h28, w); lat_m &= ~w[15:0];
         pins();
         apb(1'b0, 8'h20, 32'h0); chk("rd_lo", lo, rd);
         apb(1'b0, 8'h24, 32'h0); chk("rd_hi", hi, rd);
         apb(1'b0, 8'h28, 32'h0); chk("rd_clr", 32'h0, rd);
         chk("pready", 32'h1, {31'h0, rdy});
         apb(1'b0, 8'h14, 32'h0); chk("rd_latch", {16'h0, lat_m}, rd);
         apb(1'b0, 8'h18, 32'h0); chk("rd_sc", 32'h0, rd);
      end
      // A second reset in mid-run must bring every register back to zero.
      @(posedge i_clk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      lo = 32'h0; hi = 32'h0; lat_m = 16'h0;
      pins();
      // An unmapped address is refused with an error.
      apb(1'b0, 8'h30, 32'h0); chk("slverr", 32'h1, {31'h0, er});
      summarize();
   end
endmodule
